// ### core/msc_regs.vh
// register map and field layout of the misc sfr cluster
// assumes an 8-bit register address and 8-bit data
`ifndef MSC_REGS_VH
`define MSC_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MSC_OFS_ADC_SEL     8'h8C
`define MSC_OFS_EDGE_CTRL   8'h8D
`define MSC_OFS_CLK_CTRL    8'h8E
`define MSC_OFS_PRESCALE    8'h8F
`define MSC_OFS_PORT_ONE    8'h90
`define MSC_OFS_IRQ_FLAG    8'h91

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define MSC_WDT_SEL_HI      7
`define MSC_WDT_SEL_LO      6
`define MSC_STRETCH_HI      2
`define MSC_STRETCH_LO      0
`define MSC_PRE_HI          1
`define MSC_PRE_LO          0
`define MSC_FLAG_HI         7
`define MSC_FLAG_LO         4
`define MSC_RST_STRETCH     3'h1
`define MSC_RST_PORT        8'hFF
`define MSC_RST_BYTE        8'h00
`define MSC_MOVE_BASE       4'h2

// ----------------------------------------------------------------
// prescale codes and divide counts
// ----------------------------------------------------------------
`define MSC_PRE_DIV1        2'h0
`define MSC_PRE_DIV4        2'h1
`define MSC_PRE_DIV16       2'h2
`define MSC_PRE_DIV32       2'h3
`define MSC_DIV4_LAST       5'h03
`define MSC_DIV16_LAST      5'h0F
`define MSC_DIV32_LAST      5'h1F

// ----------------------------------------------------------------
// watchdog timing
// ----------------------------------------------------------------
`define MSC_WDT_EXP0        17
`define MSC_WDT_EXP1        20
`define MSC_WDT_EXP2        23
`define MSC_WDT_EXP3        26
`define MSC_WDT_RST_EXTRA   27'h000_0200
`define MSC_WDT_W           27

// ----------------------------------------------------------------
// edge select codes for interrupts 3 to 5
// ----------------------------------------------------------------
`define MSC_EDGE_RISE       2'h0
`define MSC_EDGE_FALL       2'h1

`endif

// ### core/msc_wdt_timer.v
// watchdog time-out counter with selectable interrupt period
// assumes run and restart come from the clock domain of clk
`include "msc_regs.vh"
`default_nettype none

module msc_wdt_timer #(
    parameter EXP0 = `MSC_WDT_EXP0,
    parameter EXP1 = `MSC_WDT_EXP1,
    parameter EXP2 = `MSC_WDT_EXP2,
    parameter EXP3 = `MSC_WDT_EXP3
) (
    input  wire       clk,          // system clock
    input  wire       resetn,       // async reset, active low
    input  wire       run,          // counter enable
    input  wire       restart,      // clears the count
    input  wire [1:0] sel,          // period select
    output reg        irq_pulse_q,  // interrupt time-out, one cycle
    output reg        rst_pulse_q   // reset time-out, one cycle
);

    reg  [`MSC_WDT_W-1:0] cnt_q;
    wire [`MSC_WDT_W-1:0] irq_at;
    wire [`MSC_WDT_W-1:0] rst_at;

    // ----------------------------------------------------------------
    // limits
    // ----------------------------------------------------------------
    function [`MSC_WDT_W-1:0] wdt_limit;
        input [1:0] s;
        begin
            case (s)
                2'h0:    wdt_limit = {{(`MSC_WDT_W-1){1'b0}}, 1'b1} << EXP0;
                2'h1:    wdt_limit = {{(`MSC_WDT_W-1){1'b0}}, 1'b1} << EXP1;
                2'h2:    wdt_limit = {{(`MSC_WDT_W-1){1'b0}}, 1'b1} << EXP2;
                default: wdt_limit = {{(`MSC_WDT_W-1){1'b0}}, 1'b1} << EXP3;
            endcase
        end
    endfunction

    assign irq_at = wdt_limit(sel);
    assign rst_at = irq_at + `MSC_WDT_RST_EXTRA;

    // pulses mark the clock in which the count of elapsed clocks reaches the limit
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q       <= {`MSC_WDT_W{1'b0}};
            irq_pulse_q <= 1'b0;
            rst_pulse_q <= 1'b0;
        end else if (restart || !run) begin
            cnt_q       <= {`MSC_WDT_W{1'b0}};
            irq_pulse_q <= 1'b0;
            rst_pulse_q <= 1'b0;
        end else begin
            cnt_q       <= cnt_q + {{(`MSC_WDT_W-1){1'b0}}, 1'b1};
            irq_pulse_q <= (cnt_q + {{(`MSC_WDT_W-1){1'b0}}, 1'b1}) == irq_at;
            rst_pulse_q <= (cnt_q + {{(`MSC_WDT_W-1){1'b0}}, 1'b1}) == rst_at;
        end
    end

endmodule // msc_wdt_timer

`default_nettype wire

// ### core/msc_sfr_cluster.v
// misc special-function register cluster: clock control, port one,
// external interrupt flags, timer 3 prescaler and watchdog period.
// assumes a single-cycle strobe register port and pins synchronous to clk.
//
// Notes on behaviour
// - watchdog interrupt time-out is 2^17, 2^20, 2^23 or 2^26 clocks by code
// - watchdog reset time-out comes exactly 512 clocks after the interrupt one
// - stretch value N makes external data moves last N plus 2 machine cycles
// - stretch resets to 1, giving three-cycle external data moves
// - ordinary port read returns the sampled pin levels
// - read-modify-write read returns the output latch instead
// - bit0 timer 2 pin, bit1 brake input, bits 2 and 3 second uart
// - flags 3 to 5 in bits 5 to 7 set on chosen rising, falling or both edges
// - flag 2 in bit 4 sets on rising edges only
`include "msc_regs.vh"
`default_nettype none

module msc_sfr_cluster #(
    parameter WDT_EXP0 = `MSC_WDT_EXP0,
    parameter WDT_EXP1 = `MSC_WDT_EXP1,
    parameter WDT_EXP2 = `MSC_WDT_EXP2,
    parameter WDT_EXP3 = `MSC_WDT_EXP3
) (
    input  wire       clk,                // 100 MHz system clock
    input  wire       resetn,             // async reset, active low
    input  wire [7:0] reg_addr,           // register address
    input  wire [7:0] reg_wdata,          // write data
    input  wire       reg_wr,             // write strobe
    input  wire       reg_rd,             // read strobe
    input  wire       reg_rd_rmw,         // read belongs to read-modify-write
    output reg  [7:0] reg_rdata_q,        // read data, cycle after strobe
    input  wire [7:0] pad_in,             // port one pin levels
    output reg  [7:0] pad_out_q,          // port one drive value
    output reg  [7:0] pad_oe_n_q,         // port one enable, low drives
    output reg  [7:0] adc_chan_en_q,      // analog channel n uses pin n
    input  wire       timer2_ext_out,     // timer 2 output to pin 0
    input  wire       timer2_ext_oen,     // timer 2 drives pin 0
    input  wire       uart_b_tx,          // second uart transmit data
    input  wire       uart_b_tx_en,       // second uart owns pin 3
    output reg        timer2_ext_pin_q,   // pin 0 level to timer 2
    output reg        pwm_brake_in_q,     // pin 1 level to pwm brake
    output reg        uart_b_rx_q,        // pin 2 level to second uart
    input  wire       ext_irq_two_pin,    // external interrupt 2 pin
    input  wire       ext_irq_three_pin,  // external interrupt 3 pin
    input  wire       ext_irq_four_pin,   // external interrupt 4 pin
    input  wire       ext_irq_five_pin,   // external interrupt 5 pin
    input  wire [3:0] irq_ack,            // acknowledge, bit0 is flag 2
    output reg  [3:0] ext_irq_flags_q,    // flags 2 to 5 to interrupt logic
    output reg  [2:0] stretch_count_q,    // external data move stretch
    output reg  [3:0] move_cyc_q,         // machine cycles per data move
    output reg        tmr3_tick_q,        // timer 3 clock enable pulse
    input  wire       wdt_run,            // watchdog running
    input  wire       wdt_restart,        // watchdog restart
    output reg        wdt_irq_q,          // watchdog interrupt time-out
    output reg        wdt_rst_q           // watchdog reset time-out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [7:0] clk_ctrl_q;      // watchdog period and stretch
    reg  [1:0] prescale_q;      // timer 3 prescale code
    reg  [7:0] port_one_latch_q;
    reg  [7:0] adc_sel_q;
    reg  [5:0] edge_ctrl_q;     // two bits each for interrupts 3 to 5
    reg  [3:0] flag_q;
    reg  [3:0] flag_d;
    reg  [3:0] pin_prev_q;
    reg  [4:0] div_cnt_q;
    reg  [7:0] rdata_d;
    reg  [7:0] drive_low;
    wire [3:0] pin_now;
    wire [3:0] rise;
    wire [3:0] fall;
    wire [3:0] hit;
    wire [4:0] div_last;
    wire       wdt_irq_w;
    wire       wdt_rst_w;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [4:0] pre_last;
        input [1:0] code;
        begin
            case (code)
                `MSC_PRE_DIV1:  pre_last = 5'h00;
                `MSC_PRE_DIV4:  pre_last = `MSC_DIV4_LAST;
                `MSC_PRE_DIV16: pre_last = `MSC_DIV16_LAST;
                default:        pre_last = `MSC_DIV32_LAST;
            endcase
        end
    endfunction

    function edge_hit;
        input [1:0] mode;
        input       r;
        input       f;
        begin
            case (mode)
                `MSC_EDGE_RISE: edge_hit = r;
                `MSC_EDGE_FALL: edge_hit = f;
                default:        edge_hit = r | f;
            endcase
        end
    endfunction

    function is_wr;
        input [7:0] ofs;
        begin
            is_wr = reg_wr && (reg_addr == ofs);
        end
    endfunction

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // stretch default one
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_ctrl_q       <= {5'h00, `MSC_RST_STRETCH};
            prescale_q       <= 2'h0;
            port_one_latch_q <= `MSC_RST_PORT;
            adc_sel_q        <= `MSC_RST_BYTE;
            edge_ctrl_q      <= 6'h00;
        end else begin
            // bits 5..3 of the clock control are other blocks' fields, held zero here
            if (is_wr(`MSC_OFS_CLK_CTRL)) begin
                clk_ctrl_q <= {reg_wdata[`MSC_WDT_SEL_HI:`MSC_WDT_SEL_LO], 3'h0,
                               reg_wdata[`MSC_STRETCH_HI:`MSC_STRETCH_LO]};
            end
            if (is_wr(`MSC_OFS_PRESCALE)) begin
                prescale_q <= reg_wdata[`MSC_PRE_HI:`MSC_PRE_LO];
            end
            if (is_wr(`MSC_OFS_PORT_ONE)) begin
                port_one_latch_q <= reg_wdata;
            end
            if (is_wr(`MSC_OFS_ADC_SEL)) begin
                adc_sel_q <= reg_wdata;
            end
            if (is_wr(`MSC_OFS_EDGE_CTRL)) begin
                edge_ctrl_q <= reg_wdata[5:0];
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stretch_count_q <= `MSC_RST_STRETCH;
            move_cyc_q      <= `MSC_MOVE_BASE + {1'b0, `MSC_RST_STRETCH};
        end else begin
            stretch_count_q <= clk_ctrl_q[`MSC_STRETCH_HI:`MSC_STRETCH_LO];
            move_cyc_q      <= `MSC_MOVE_BASE +
                               {1'b0, clk_ctrl_q[`MSC_STRETCH_HI:`MSC_STRETCH_LO]};
        end
    end

    // ----------------------------------------------------------------
    // timer 3 prescaler
    // ----------------------------------------------------------------
    assign div_last = pre_last(prescale_q);

    // prescaled timer 3 enable
    // a code change restarts the count so the first tick is never short by a wrap
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_q   <= 5'h00;
            tmr3_tick_q <= 1'b0;
        end else if (is_wr(`MSC_OFS_PRESCALE)) begin
            div_cnt_q   <= 5'h00;
            tmr3_tick_q <= 1'b0;
        end else if (div_cnt_q >= div_last) begin
            div_cnt_q   <= 5'h00;
            tmr3_tick_q <= 1'b1;
        end else begin
            div_cnt_q   <= div_cnt_q + 5'h01;
            tmr3_tick_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // port one pins
    // ----------------------------------------------------------------
    // alternate outputs merge
    // quasi-bidirectional: a pin is pulled low when latch or alternate says zero, unless adc_sel_q selects it for its analog channel
    always @* begin
        drive_low    = ~port_one_latch_q;
        drive_low[0] = ~port_one_latch_q[0] | (timer2_ext_oen & ~timer2_ext_out);
        drive_low[3] = ~port_one_latch_q[3] | (uart_b_tx_en & ~uart_b_tx);
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pad_out_q     <= 8'h00;
            pad_oe_n_q    <= 8'hFF;
            adc_chan_en_q <= 8'h00;
        end else begin
            pad_out_q     <= 8'h00;
            pad_oe_n_q    <= ~drive_low | adc_sel_q;
            adc_chan_en_q <= adc_sel_q;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timer2_ext_pin_q <= 1'b1;
            pwm_brake_in_q   <= 1'b1;
            uart_b_rx_q      <= 1'b1;
        end else begin
            timer2_ext_pin_q <= pad_in[0];
            pwm_brake_in_q   <= pad_in[1];
            uart_b_rx_q      <= pad_in[2];
        end
    end

    // ----------------------------------------------------------------
    // external interrupt flags
    // ----------------------------------------------------------------
    assign pin_now = {ext_irq_five_pin, ext_irq_four_pin, ext_irq_three_pin,
                      ext_irq_two_pin};
    assign rise    = pin_now & ~pin_prev_q;
    assign fall    = ~pin_now & pin_prev_q;

    assign hit[0] = rise[0];
    assign hit[1] = edge_hit(edge_ctrl_q[1:0], rise[1], fall[1]);
    assign hit[2] = edge_hit(edge_ctrl_q[3:2], rise[2], fall[2]);
    assign hit[3] = edge_hit(edge_ctrl_q[5:4], rise[3], fall[3]);

    always @* begin
        flag_d = flag_q & ~irq_ack;
        if (is_wr(`MSC_OFS_IRQ_FLAG)) begin
            flag_d = reg_wdata[`MSC_FLAG_HI:`MSC_FLAG_LO] & ~irq_ack;
        end
        flag_d = flag_d | hit;
    end

    // previous pin levels start high so a pin held high from reset is not a rising edge
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_prev_q      <= 4'hF;
            flag_q          <= 4'h0;
            ext_irq_flags_q <= 4'h0;
        end else begin
            pin_prev_q      <= pin_now;
            flag_q          <= flag_d;
            ext_irq_flags_q <= flag_d;
        end
    end

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    msc_wdt_timer #(
        .EXP0 (WDT_EXP0),
        .EXP1 (WDT_EXP1),
        .EXP2 (WDT_EXP2),
        .EXP3 (WDT_EXP3)
    ) u_wdt (
        .clk         (clk),
        .resetn      (resetn),
        .run         (wdt_run),
        .restart     (wdt_restart),
        .sel         (clk_ctrl_q[`MSC_WDT_SEL_HI:`MSC_WDT_SEL_LO]),
        .irq_pulse_q (wdt_irq_w),
        .rst_pulse_q (wdt_rst_w)
    );

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdt_irq_q <= 1'b0;
            wdt_rst_q <= 1'b0;
        end else begin
            wdt_irq_q <= wdt_irq_w;
            wdt_rst_q <= wdt_rst_w;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // pins on plain read
    always @* begin
        case (reg_addr)
            `MSC_OFS_ADC_SEL:   rdata_d = adc_sel_q;
            `MSC_OFS_EDGE_CTRL: rdata_d = {2'h0, edge_ctrl_q};
            `MSC_OFS_CLK_CTRL:  rdata_d = clk_ctrl_q;
            `MSC_OFS_PRESCALE:  rdata_d = {6'h00, prescale_q};
            `MSC_OFS_PORT_ONE:  rdata_d = reg_rd_rmw ? port_one_latch_q : pad_in;
            `MSC_OFS_IRQ_FLAG:  rdata_d = {flag_q, 4'h0};
            default:            rdata_d = 8'h00;
        endcase
    end

    // data stand only in the cycle after the strobe, zero otherwise
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

endmodule // msc_sfr_cluster

`default_nettype wire

// ### tb/msc_pin_model.sv
// pin model: open-drain port one lines with pull-ups
// assumes the bench steers the external pull-downs
`default_nettype none

module msc_pin_model (
    input  wire logic [7:0] pad_oe_n_q, // design enable, low pulls low
    input  wire logic [7:0] ext_low,    // external pull-down per pin
    output var  logic [7:0] pad_in      // resolved pin levels
);
    timeunit 1ns;
    timeprecision 1ns;

    // wired-and pins
    // a pin reads high only while nobody pulls it low, never a stale value
    always_comb pad_in = pad_oe_n_q & ~ext_low;
endmodule // msc_pin_model

`default_nettype wire

// ### tb/msc_sfr_cluster_sva.sv
// port checker for the misc sfr cluster
// assumes pins high and strobes low while reset is held
`default_nettype none

module msc_sfr_cluster_sva (
    input wire logic       clk,              // clock
    input wire logic       resetn,           // reset, active low
    input wire logic [7:0] reg_addr,         // address
    input wire logic       reg_wr,           // write strobe
    input wire logic       reg_rd,           // read strobe
    input wire logic       reg_rd_rmw,       // rmw read
    input wire logic [7:0] reg_rdata_q,      // read data
    input wire logic [7:0] pad_in,           // pin levels
    input wire logic       ext_irq_two_pin,  // interrupt 2 pin
    input wire logic [3:0] irq_ack,          // acknowledge
    input wire logic [3:0] ext_irq_flags_q,  // flags 2 to 5
    input wire logic [2:0] stretch_count_q,  // stretch
    input wire logic [3:0] move_cyc_q,       // move length
    input wire logic       timer2_ext_pin_q, // pin 0 alt
    input wire logic       pwm_brake_in_q,   // pin 1 alt
    input wire logic       uart_b_rx_q,      // pin 2 alt
    input wire logic       wdt_irq_q,        // wdt interrupt
    input wire logic       wdt_rst_q         // wdt reset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    wire flag_wr = reg_wr && (reg_addr == 8'h91);
    wire rd_gap = reg_rd && (reg_addr < 8'h8C || reg_addr > 8'h91);

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_rise2; !ext_irq_two_pin ##1 ext_irq_two_pin; endsequence
    sequence s_fall2; ext_irq_two_pin ##1 !ext_irq_two_pin; endsequence
    // reset must stay low for 8 cycles, then lands exactly 512 after the interrupt
    sequence s_rst_gap; !wdt_rst_q [*8] ##[504:504] wdt_rst_q; endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_move_len; move_cyc_q == {1'b0, stretch_count_q} + 4'h2; endproperty
    property p_rise2; s_rise2 |=> ext_irq_flags_q[0]; endproperty
    property p_fall2; s_fall2 ##0 (!ext_irq_flags_q[0] && !flag_wr) |=> !ext_irq_flags_q[0];
    endproperty
    property p_hold;
        !flag_wr |=> ($past(ext_irq_flags_q) & ~$past(irq_ack) & ~ext_irq_flags_q) == 4'h0;
    endproperty
    property p_pin_rd;
        reg_rd && reg_addr == 8'h90 && !reg_rd_rmw |=> reg_rdata_q == $past(pad_in);
    endproperty
    property p_rsvd_flag; reg_rd && reg_addr == 8'h91 |=> reg_rdata_q[3:0] == 4'h0; endproperty
    property p_rsvd_pre; reg_rd && reg_addr == 8'h8F |=> reg_rdata_q[7:2] == 6'h00; endproperty
    property p_gap; rd_gap |=> reg_rdata_q == 8'h00; endproperty
    property p_alt;
        {uart_b_rx_q, pwm_brake_in_q, timer2_ext_pin_q} == $past(pad_in[2:0]);
    endproperty
    property p_rst_gap; wdt_irq_q |=> s_rst_gap; endproperty

    a_move_len: assert property (p_move_len) else $error("move length mismatch");
    a_rise2: assert property (p_rise2) else $error("flag2 missed rise");
    a_fall2: assert property (p_fall2) else $error("flag2 set on fall");
    a_hold: assert property (p_hold) else $error("flag dropped early");
    a_pin_rd: assert property (p_pin_rd) else $error("port read not pins");
    a_rsvd_flag: assert property (p_rsvd_flag) else $error("flag low bits");
    a_rsvd_pre: assert property (p_rsvd_pre) else $error("prescale high bits");
    a_gap: assert property (p_gap) else $error("unmapped read not zero");
    a_alt: assert property (p_alt) else $error("alternate input lag");
    a_rst_gap: assert property (p_rst_gap) else $error("reset time-out gap");
endmodule // msc_sfr_cluster_sva

bind msc_sfr_cluster msc_sfr_cluster_sva msc_sfr_cluster_sva_inst (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_rmw(reg_rd_rmw), .reg_rdata_q(reg_rdata_q), .pad_in(pad_in),
    .ext_irq_two_pin(ext_irq_two_pin), .irq_ack(irq_ack), .ext_irq_flags_q(ext_irq_flags_q),
    .stretch_count_q(stretch_count_q), .move_cyc_q(move_cyc_q),
    .timer2_ext_pin_q(timer2_ext_pin_q), .pwm_brake_in_q(pwm_brake_in_q),
    .uart_b_rx_q(uart_b_rx_q), .wdt_irq_q(wdt_irq_q), .wdt_rst_q(wdt_rst_q));

`default_nettype wire

// ### tb/test_msc_sfr_cluster.sv
// self-checking bench for the misc sfr cluster
// assumes the pin model and the bound checker are compiled with it
`default_nettype none

module test_msc_sfr_cluster;
    timeunit 1ns;
    timeprecision 1ns;

    // small watchdog exponents keep the run short
    localparam int E0 = 4;
    localparam int E1 = 5;
    localparam int E2 = 6;
    localparam int E3 = 7;
    int ex[4] = '{E0, E1, E2, E3};
    int dv[4] = '{1, 4, 16, 32};
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] ext_low = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       reg_rd_rmw = 1'b0;
    logic       tm2_out = 1'b1;
    logic       tm2_oen = 1'b0;
    logic       tx = 1'b1;
    logic       tx_en = 1'b0;
    logic [3:0] irq_pin = 4'h0;
    logic [3:0] irq_ack = 4'h0;
    logic       wdt_run = 1'b0;
    logic       wdt_restart = 1'b0;
    logic       rd_seen = 1'b0;
    logic [15:0] seed = 16'h8C6F;
    logic [7:0] exp_q[$];
    wire  [7:0] rdata, pin_in, oe_n, adc, pout;
    wire  [3:0] flags, mvc;
    wire  [2:0] stretch;
    wire        tick, wirq, wrst, alt0, alt1, alt2;
    int         fail_count = 0;
    int         compares = 0;

    msc_sfr_cluster #(.WDT_EXP0(E0), .WDT_EXP1(E1), .WDT_EXP2(E2), .WDT_EXP3(E3))
    msc_sfr_cluster_inst (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_rmw(reg_rd_rmw), .reg_rdata_q(rdata),
        .pad_in(pin_in), .pad_out_q(pout), .pad_oe_n_q(oe_n), .adc_chan_en_q(adc),
        .timer2_ext_out(tm2_out), .timer2_ext_oen(tm2_oen), .uart_b_tx(tx),
        .uart_b_tx_en(tx_en), .timer2_ext_pin_q(alt0), .pwm_brake_in_q(alt1),
        .uart_b_rx_q(alt2), .ext_irq_two_pin(irq_pin[0]), .ext_irq_three_pin(irq_pin[1]),
        .ext_irq_four_pin(irq_pin[2]), .ext_irq_five_pin(irq_pin[3]), .irq_ack(irq_ack),
        .ext_irq_flags_q(flags), .stretch_count_q(stretch), .move_cyc_q(mvc),
        .tmr3_tick_q(tick), .wdt_run(wdt_run), .wdt_restart(wdt_restart),
        .wdt_irq_q(wirq), .wdt_rst_q(wrst));
    msc_pin_model msc_pin_model_inst (.pad_oe_n_q(oe_n), .ext_low(ext_low), .pad_in(pin_in));

    // ----------------------------------------------------------------
    // clock, helpers and bus tasks
    // ----------------------------------------------------------------
    always #5 clk = ~clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // every bus cycle drives all strobes, so no signal is assigned twice per step
    task automatic bus(input logic w, input logic r, input logic m, input logic [7:0] a,
                       input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_rd_rmw <= m;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) bus(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, m, a, 8'h00);
    endtask

    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe, so look there
    always @(posedge clk) begin
        rd_seen <= reg_rd;
        if (rd_seen)
            check("rdata", rdata, exp_q.pop_front());
    end

    // watchdog on the whole run
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] d;
        int k;
        int t0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        cyc(1);
        check("move reset", mvc, 4'h3);
        check("pad out", pout, 8'h00);
        rd(8'h8E, 1'b0, 8'h01);
        rd(8'h8F, 1'b0, 8'h00);
        rd(8'h91, 1'b0, 8'h00);
        rd(8'h90, 1'b0, 8'hFF);
        wr(8'hA0, 8'h55);
        rd(8'hA0, 1'b0, 8'h00);
        // every stretch code, random upper bits
        for (int n = 0; n < 8; n++) begin
            seed = lfsr(seed);
            d = {seed[7:3], n[2:0]};
            wr(8'h8E, d);
            cyc(2);
            check("stretch", stretch, n[2:0]);
            check("move", mvc, n + 2);
            rd(8'h8E, 1'b0, d & 8'hC7);
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h8F, {6'h3F, c[1:0]});
            rd(8'h8F, 1'b0, c[1:0]);
            cyc(4);
            k = 0;
            repeat (64) begin
                cyc(1);
                k += (tick === 1'b1);
            end
            check("ticks", k, 64 / dv[c]);
        end
        ext_low <= 8'h10;
        wr(8'h90, 8'hFE);
        cyc(3);
        check("oe", oe_n, 8'hFE);
        rd(8'h90, 1'b0, 8'hEE);
        rd(8'h90, 1'b1, 8'hFE);
        ext_low <= 8'h14;
        cyc(3);
        check("alt", {alt2, alt1, alt0}, 3'b010);
        wr(8'h8C, 8'h01);
        cyc(3);
        check("adc", adc, 8'h01);
        check("oe adc", oe_n[0], 1'b1);
        check("alt0", alt0, 1'b1);
        // timer 2 and second uart drive their pins
        wr(8'h8C, 8'h00);
        wr(8'h90, 8'hFF);
        ext_low <= 8'h00;
        tm2_oen <= 1'b1;
        tm2_out <= 1'b0;
        tx_en <= 1'b1;
        tx <= 1'b0;
        cyc(3);
        check("oe alt", oe_n, 8'hF6);
        tm2_oen <= 1'b0;
        tx_en <= 1'b0;
        // edge kinds: irq 3 rise, irq 4 fall, irq 5 both
        wr(8'h8D, 8'h24);
        cyc(1);
        irq_pin <= 4'hF;
        cyc(3);
        rd(8'h91, 1'b0, 8'hB0);
        check("flags", flags, 4'hB);
        wr(8'h91, 8'h00);
        irq_pin <= 4'h0;
        cyc(3);
        rd(8'h91, 1'b0, 8'hC0);
        irq_ack <= 4'h8;
        cyc(1);
        irq_ack <= 4'h0;
        cyc(2);
        rd(8'h91, 1'b0, 8'h40);
        irq_pin <= 4'h1;
        cyc(2);
        wr(8'h91, 8'h00);
        cyc(1);
        irq_pin <= 4'h0;
        cyc(2);
        rd(8'h91, 1'b0, 8'h00);
        wdt_run <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(8'h8E, {s[1:0], 6'h01});
            wdt_restart <= 1'b1;
            cyc(1);
            wdt_restart <= 1'b0;
            t0 = 0;
            while (wirq !== 1'b1 && t0 < 400) begin
                cyc(1);
                t0++;
            end
            check("wdt irq", t0, (1 << ex[s]) + 2);
            t0 = 0;
            while (wrst !== 1'b1 && t0 < 600) begin
                cyc(1);
                t0++;
            end
            check("wdt gap", t0, 512);
        end
        cyc(3);
        end_sim();
    end
endmodule // test_msc_sfr_cluster

`default_nettype wire
